// ==== inc/vsm_pkg.sv ====
package vsm_pkg;
    localparam logic [7:0] REG_STD_OFS = 8'h04;
    localparam logic [7:0] REG_MIX_OFS = 8'h05;
    localparam logic [7:0] REG_WGT_OFS = 8'h06;
    localparam logic [7:0] STD_RST = 8'h01;
    localparam logic [7:0] MIX_RST = 8'h20;
    localparam logic [7:0] WGT_RST = 8'h01;

    localparam int STD_FIRST_LSB = 3;
    localparam int STD_SECOND_LSB = 0;
    localparam int MIX_OVL_BIT = 5;
    localparam int MIX_MODE_LSB = 2;
    localparam int MIX_COMP_BIT = 1;
    localparam int MIX_PHS_BIT = 0;
    localparam int STD_ENTRIES = 8;

    localparam logic [7:0] FULL_WEIGHT = 8'hff;
    localparam logic [7:0] ZERO_WEIGHT = 8'h00;
    localparam logic [16:0] ROUND_HALF = 17'h0007f;
    localparam logic [16:0] WEIGHT_DIV = 17'h000ff;
    localparam logic [7:0] CHROMA_MID = 8'h80;
    localparam logic [7:0] OVL_LIMIT = 8'h70;
    localparam logic [3:0] SCALE_UNITY = 4'h8;
    localparam int FIFO_DEPTH = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [2:0] SLOPE_ONE = 3'h1;

    localparam logic [2:0] MODE_ALPHA_RGB = 3'h4;
    localparam logic [2:0] MODE_ALPHA_CVBS = 3'h5;
    localparam logic [2:0] MODE_FORCE_CVBS = 3'h6;
    localparam logic [2:0] MODE_FORCE_RGB = 3'h7;

    // standard codes for the search table
    typedef enum logic [2:0] {
        STD_PAL_BGDHI = 3'h0,
        STD_SECAM = 3'h1,
        STD_NTSC_M = 3'h2,
        STD_PAL_M = 3'h3,
        STD_PAL_N = 3'h4,
        STD_NTSC_443 = 3'h5,
        STD_NONE_A = 3'h6,
        STD_NONE_B = 3'h7
    } vsm_std_t;

    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cr;
        logic [7:0] cb;
    } vsm_pix_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } vsm_reg_req_t;
endpackage

// ==== src/vsm_fifo.sv ====
module vsm_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic in_ready_ff;
    logic out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;
    logic push;
    logic pop;
    logic [AW:0] nxt_count;

    // output stage refills from memory so both ready and valid are flops
    assign push = in_valid && in_ready_ff;
    assign pop = (count_ff != '0) && (!out_valid_ff || out_ready);
    assign nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            in_ready_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= nxt_count;
            in_ready_ff <= (nxt_count != DEPTH_CNT);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else if (pop) begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem_ff[rd_ptr_ff];
        end else if (out_ready) begin
            out_valid_ff <= 1'b0;
        end
    end

    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = out_data_ff;
endmodule

// ==== src/vsm_mixer.sv ====
module vsm_mixer #(
    parameter int FIFO_WORDS = vsm_pkg::FIFO_DEPTH
) (
    // clock and reset, ref_clk is the 4x subcarrier clock
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input vsm_pkg::vsm_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // pixel inputs, both paths aligned
    input vsm_pkg::vsm_pix_t pix_cvbs,
    input vsm_pkg::vsm_pix_t pix_rgb,
    input wire logic pix_in_valid,
    output logic pix_in_ready,
    // video timing and overlay pin
    input wire logic active_line,
    input wire logic overlay_select_input,
    // mixed pixel output
    output vsm_pkg::vsm_pix_t pix_out,
    output logic pix_out_valid,
    input wire logic pix_out_ready,
    // controls to the search engine and output pll
    output logic [2:0] std_entry_first,
    output logic [2:0] std_entry_second,
    output logic phase_jump_enable
);
    logic rst_meta_n_ff;
    logic rst_sync_n_ff;
    logic [7:0] std_ff;
    logic [7:0] mix_ff;
    logic [7:0] wgt_ff;
    logic [7:0] reg_rdata_ff;
    logic phase_jump_enable_ff;
    logic fb_s1_ff;
    logic fb_s2_ff;
    logic fb_s3_ff;
    logic fb_lvl_ff;
    logic [7:0] wgt_cur_ff;
    logic [7:0] wgt_start_ff;
    logic [7:0] wgt_tgt_ff;
    logic [2:0] ramp_k_ff;
    logic [2:0] ramp_n_ff;
    logic [7:0] peak_ff;
    logic [3:0] scale_ff;
    logic act_d_ff;
    logic [2:0] mode;
    logic comp_mode;
    logic soft_mode;
    logic sat_mode;
    logic [7:0] nxt_tgt;
    logic [2:0] slope_len;
    logic [3:0] eff_scale;
    logic [7:0] line_peak;
    vsm_pkg::vsm_pix_t rgb_adj;
    vsm_pkg::vsm_pix_t mixed;
    logic push;
    logic fifo_ready;
    logic [23:0] fifo_q;

    function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] p,
                                         input logic [7:0] q);
        logic [16:0] acc;
        acc = 17'(a) * 17'(p) + 17'(vsm_pkg::FULL_WEIGHT - a) * 17'(q) + vsm_pkg::ROUND_HALF;
        return 8'(acc / vsm_pkg::WEIGHT_DIV);
    endfunction

    function automatic vsm_pkg::vsm_pix_t mix_pix(input logic [7:0] a,
                                                 input vsm_pkg::vsm_pix_t p,
                                                 input vsm_pkg::vsm_pix_t q);
        vsm_pkg::vsm_pix_t r;
        r.y = blend(a, p.y, q.y);
        r.cr = blend(a, p.cr, q.cr);
        r.cb = blend(a, p.cb, q.cb);
        return r;
    endfunction

    // equal steps: weight after k of n steps from s towards t
    function automatic logic [7:0] ramp(input logic [7:0] s, input logic [7:0] t,
                                        input logic [2:0] k, input logic [2:0] n);
        logic [10:0] d;
        logic [10:0] q;
        d = 11'((t >= s) ? t - s : s - t) * 11'(k);
        case (n)
            3'h1: q = d;
            3'h2: q = d >> 1;
            3'h3: q = d / 11'h003;
            default: q = d >> 2;
        endcase
        return (t >= s) ? s + q[7:0] : s - q[7:0];
    endfunction

    function automatic logic [7:0] chroma_dev(input logic [7:0] c);
        return (c >= vsm_pkg::CHROMA_MID) ? c - vsm_pkg::CHROMA_MID : vsm_pkg::CHROMA_MID - c;
    endfunction

    // largest eighths factor that keeps the line peak within the limit
    function automatic logic [3:0] pick_scale(input logic [7:0] peak);
        logic [3:0] r;
        r = 4'h1;
        for (int i = 1; i <= 8; i++) begin
            if (11'(peak) * 11'(i) <= 11'(vsm_pkg::OVL_LIMIT) * 11'h008) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] scale_c(input logic [7:0] c, input logic [3:0] s);
        logic [11:0] d;
        d = (12'(chroma_dev(c)) * 12'(s)) >> 3;
        return (c >= vsm_pkg::CHROMA_MID) ? vsm_pkg::CHROMA_MID + d[7:0]
                                          : vsm_pkg::CHROMA_MID - d[7:0];
    endfunction

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n_ff <= 1'b0;
            rst_sync_n_ff <= 1'b0;
        end else begin
            rst_meta_n_ff <= 1'b1;
            rst_sync_n_ff <= rst_meta_n_ff;
        end
    end

    // reserved bits 7:6 of the standard and mix registers are not stored, they read back as zero
    always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            std_ff <= vsm_pkg::STD_RST;
            mix_ff <= vsm_pkg::MIX_RST;
            wgt_ff <= vsm_pkg::WGT_RST;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                vsm_pkg::REG_STD_OFS: std_ff <= {2'h0, reg_req.wdata[5:0]};
                vsm_pkg::REG_MIX_OFS: mix_ff <= {2'h0, reg_req.wdata[5:0]};
                vsm_pkg::REG_WGT_OFS: wgt_ff <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                vsm_pkg::REG_STD_OFS: reg_rdata_ff <= std_ff;
                vsm_pkg::REG_MIX_OFS: reg_rdata_ff <= mix_ff;
                vsm_pkg::REG_WGT_OFS: reg_rdata_ff <= wgt_ff;
                default: reg_rdata_ff <= 8'h00;
            endcase
        end
    end

    // output pll sees the jump permission two cycles after the write request
    always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            phase_jump_enable_ff <= 1'b1;
        end else begin
            phase_jump_enable_ff <= !mix_ff[vsm_pkg::MIX_PHS_BIT];
        end
    end

    // overlay pin: three flops, level accepted when the last two agree
    always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            fb_s1_ff <= 1'b0;
            fb_s2_ff <= 1'b0;
            fb_s3_ff <= 1'b0;
            fb_lvl_ff <= 1'b0;
        end else begin
            fb_s1_ff <= overlay_select_input;
            fb_s2_ff <= fb_s1_ff;
            fb_s3_ff <= fb_s2_ff;
            if (fb_s2_ff == fb_s3_ff) begin
                fb_lvl_ff <= fb_s3_ff;
            end
        end
    end

    assign mode = mix_ff[vsm_pkg::MIX_MODE_LSB +: 3];
    assign comp_mode = mix_ff[vsm_pkg::MIX_COMP_BIT];
    assign soft_mode = !mode[2];
    assign sat_mode = (mode[2:1] == 2'b01);
    assign slope_len = {1'b0, wgt_ff[1:0]} + 3'h1;

    // overlay only counts inside the active line; saturated mode caps at the register
    always_comb begin
        nxt_tgt = vsm_pkg::ZERO_WEIGHT;
        if (fb_lvl_ff && active_line) begin
            nxt_tgt = sat_mode ? wgt_ff : vsm_pkg::FULL_WEIGHT;
        end
    end

    // soft weight runs on every clock, independent of pixel flow
    always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            wgt_cur_ff <= vsm_pkg::ZERO_WEIGHT;
            wgt_start_ff <= vsm_pkg::ZERO_WEIGHT;
            wgt_tgt_ff <= vsm_pkg::ZERO_WEIGHT;
            ramp_k_ff <= vsm_pkg::SLOPE_ONE;
            ramp_n_ff <= vsm_pkg::SLOPE_ONE;
        end else if (nxt_tgt != wgt_tgt_ff) begin
            wgt_tgt_ff <= nxt_tgt;
            wgt_start_ff <= wgt_cur_ff;
            ramp_k_ff <= vsm_pkg::SLOPE_ONE;
            ramp_n_ff <= slope_len;
            wgt_cur_ff <= ramp(wgt_cur_ff, nxt_tgt, vsm_pkg::SLOPE_ONE, slope_len);
        end else if (ramp_k_ff < ramp_n_ff) begin
            ramp_k_ff <= ramp_k_ff + 3'h1;
            wgt_cur_ff <= ramp(wgt_start_ff, wgt_tgt_ff, ramp_k_ff + 3'h1, ramp_n_ff);
        end
    end

    // chroma peak per line; factor updated at line end, so it lags one line
    always_comb begin
        line_peak = peak_ff;
        if (chroma_dev(pix_rgb.cr) > line_peak) begin
            line_peak = chroma_dev(pix_rgb.cr);
        end
        if (chroma_dev(pix_rgb.cb) > line_peak) begin
            line_peak = chroma_dev(pix_rgb.cb);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            peak_ff <= 8'h00;
            scale_ff <= vsm_pkg::SCALE_UNITY;
            act_d_ff <= 1'b0;
        end else begin
            act_d_ff <= active_line;
            if (act_d_ff && !active_line) begin
                scale_ff <= pick_scale(peak_ff);
                peak_ff <= 8'h00;
            end else if (active_line && push) begin
                peak_ff <= line_peak;
            end
        end
    end

    assign eff_scale = mix_ff[vsm_pkg::MIX_OVL_BIT] ? scale_ff : vsm_pkg::SCALE_UNITY;

    always_comb begin
        rgb_adj.y = pix_rgb.y;
        rgb_adj.cr = scale_c(pix_rgb.cr, eff_scale);
        rgb_adj.cb = scale_c(pix_rgb.cb, eff_scale);
        if (comp_mode) begin
            // component input overrides every blend mode
            mixed.y = pix_cvbs.y;
            mixed.cr = rgb_adj.cr;
            mixed.cb = rgb_adj.cb;
        end else begin
            case (mode)
                vsm_pkg::MODE_ALPHA_RGB: mixed = mix_pix(wgt_ff, rgb_adj, pix_cvbs);
                vsm_pkg::MODE_ALPHA_CVBS: mixed = mix_pix(wgt_ff, pix_cvbs, rgb_adj);
                vsm_pkg::MODE_FORCE_CVBS: mixed = pix_cvbs;
                vsm_pkg::MODE_FORCE_RGB: mixed = rgb_adj;
                default: mixed = mix_pix(wgt_cur_ff, rgb_adj, pix_cvbs);
            endcase
        end
    end

    // a full fifo drops pix_in_ready, stalling the sources
    assign push = pix_in_valid && fifo_ready;

    vsm_fifo #(
        .WIDTH($bits(vsm_pkg::vsm_pix_t)),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_sync_n_ff),
        .in_data(mixed),
        .in_valid(pix_in_valid),
        .in_ready(fifo_ready),
        .out_data(fifo_q),
        .out_valid(pix_out_valid),
        .out_ready(pix_out_ready)
    );

    assign pix_in_ready = fifo_ready;
    assign pix_out = fifo_q;
    assign reg_rdata = reg_rdata_ff;
    assign phase_jump_enable = phase_jump_enable_ff;
    assign std_entry_first = std_ff[vsm_pkg::STD_FIRST_LSB +: 3];
    assign std_entry_second = std_ff[vsm_pkg::STD_SECOND_LSB +: 3];

    default clocking cb_main @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n_ff);

    AST_STD_WRITE: assert property (
        reg_req.wr && reg_req.addr == vsm_pkg::REG_STD_OFS
        |=> std_entry_first == $past(reg_req.wdata[5:3])
            && std_entry_second == $past(reg_req.wdata[2:0]))
        else $error("search entries not updated");
    AST_OVL_OFF: assert property (
        push && !mix_ff[vsm_pkg::MIX_OVL_BIT] && !comp_mode && mode == vsm_pkg::MODE_FORCE_RGB
        |-> mixed == pix_rgb)
        else $error("rgb chroma altered with overload off");
    AST_COMP_SPLIT: assert property (
        push && comp_mode && !mix_ff[vsm_pkg::MIX_OVL_BIT]
        |-> mixed.y == pix_cvbs.y && mixed.cr == pix_rgb.cr && mixed.cb == pix_rgb.cb)
        else $error("component split wrong");
    AST_FORCE_CVBS: assert property (
        push && !comp_mode && mode == vsm_pkg::MODE_FORCE_CVBS |-> mixed == pix_cvbs)
        else $error("forced composite wrong");
    AST_ALPHA_FULL_RGB: assert property (
        push && !comp_mode && !mix_ff[vsm_pkg::MIX_OVL_BIT] && mode == vsm_pkg::MODE_ALPHA_RGB
        && wgt_ff == vsm_pkg::FULL_WEIGHT |-> mixed == pix_rgb)
        else $error("alpha one not rgb");
    AST_ALPHA_FULL_CVBS: assert property (
        push && !comp_mode && mode == vsm_pkg::MODE_ALPHA_CVBS
        && wgt_ff == vsm_pkg::FULL_WEIGHT |-> mixed == pix_cvbs)
        else $error("alpha one not composite");
    AST_RAMP_START: assert property (
        nxt_tgt != wgt_tgt_ff |=> ramp_k_ff == 3'h1 && ramp_n_ff == $past(slope_len))
        else $error("ramp length wrong");
    AST_RAMP_END: assert property (
        ramp_k_ff == ramp_n_ff |-> wgt_cur_ff == wgt_tgt_ff)
        else $error("ramp misses target");
    AST_IDLE_ZERO: assert property (
        (!active_line)[*5] |-> wgt_cur_ff == vsm_pkg::ZERO_WEIGHT)
        else $error("weight not zero outside line");
    AST_PHASE_DIS: assert property (
        reg_req.wr && reg_req.addr == vsm_pkg::REG_MIX_OFS && reg_req.wdata[0]
        |=> ##1 !phase_jump_enable)
        else $error("phase jumps not suppressed");
    AST_SOFT_ZERO: assert property (
        push && !comp_mode && soft_mode && wgt_cur_ff == vsm_pkg::ZERO_WEIGHT
        |-> mixed == pix_cvbs)
        else $error("zero soft weight not composite");
    AST_SAT_TARGET: assert property (
        sat_mode && fb_lvl_ff && active_line |=> wgt_tgt_ff == $past(wgt_ff))
        else $error("saturated target not the weight register");
    AST_ALPHA_ZERO_RGB: assert property (
        push && !comp_mode && mode == vsm_pkg::MODE_ALPHA_RGB
        && wgt_ff == vsm_pkg::ZERO_WEIGHT |-> mixed == pix_cvbs)
        else $error("alpha zero not composite");
    AST_RAMP_STEP: assert property (
        nxt_tgt == wgt_tgt_ff && ramp_k_ff < ramp_n_ff && wgt_tgt_ff >= wgt_start_ff
        |=> wgt_cur_ff >= $past(wgt_cur_ff) && wgt_cur_ff <= wgt_tgt_ff)
        else $error("ramp step not towards target");

    COV_SOFT_LONG: cover property (ramp_n_ff == 3'h4 && ramp_k_ff == 3'h4);
    COV_COMP: cover property (push && comp_mode);
    COV_ALPHA: cover property (push && mode == vsm_pkg::MODE_ALPHA_CVBS);
    COV_FULL: cover property (pix_in_valid && !pix_in_ready);
    COV_SAT: cover property (push && sat_mode && fb_lvl_ff && active_line);
endmodule

// ==== verif/vsm_src_model.sv ====
module vsm_src_model (
    // clock
    input wire logic clk,
    // pixel pair offer
    output vsm_pkg::vsm_pix_t pix_cvbs,
    output vsm_pkg::vsm_pix_t pix_rgb,
    output logic pix_in_valid,
    input wire logic pix_in_ready,
    // line timing and overlay pin
    output logic active_line,
    output logic overlay_select_input
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pix_cvbs = '0;
        pix_rgb = '0;
        pix_in_valid = 1'b0;
        active_line = 1'b0;
        overlay_select_input = 1'b0;
    end

    task automatic set_line(input logic a, input logic o);
        @(posedge clk);
        active_line <= a;
        overlay_select_input <= o;
    endtask

    // ready is a flop, so the level seen 1ns after an edge holds until the next
    task automatic send(input vsm_pkg::vsm_pix_t c, input vsm_pkg::vsm_pix_t r, output bit ok);
        logic rdy;
        ok = 1'b0;
        @(posedge clk);
        pix_cvbs <= c;
        pix_rgb <= r;
        pix_in_valid <= 1'b1;
        for (int i = 0; i < 200 && !ok; i++) begin
            #1;
            rdy = pix_in_ready;
            @(posedge clk);
            ok = (rdy === 1'b1);
        end
        pix_in_valid <= 1'b0;
        // released lines show the inverse, never a stale pixel
        pix_cvbs <= ~c;
        pix_rgb <= ~r;
    endtask
endmodule

// ==== verif/tb_video_source_mixer_control.sv ====
module tb_video_source_mixer_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    vsm_pkg::vsm_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    vsm_pkg::vsm_pix_t pix_cvbs;
    vsm_pkg::vsm_pix_t pix_rgb;
    vsm_pkg::vsm_pix_t pix_out;
    logic pix_in_valid;
    logic pix_in_ready;
    logic active_line;
    logic overlay_select_input;
    logic pix_out_valid;
    logic pix_out_ready = 1'b0;
    logic [2:0] std_entry_first;
    logic [2:0] std_entry_second;
    logic phase_jump_enable;
    logic [1:0] drain_mode = 2'h1;
    logic [31:0] seed = 32'h62;
    logic [7:0] a;
    logic [7:0] w;
    int n_mismatch = 0;
    int check_count = 0;
    vsm_pkg::vsm_pix_t exp_q[$];

    always #5 ref_clk = ~ref_clk;

    vsm_mixer #(.FIFO_WORDS(vsm_pkg::FIFO_DEPTH)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .pix_cvbs(pix_cvbs), .pix_rgb(pix_rgb), .pix_in_valid(pix_in_valid),
        .pix_in_ready(pix_in_ready), .active_line(active_line),
        .overlay_select_input(overlay_select_input), .pix_out(pix_out),
        .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
        .std_entry_first(std_entry_first), .std_entry_second(std_entry_second),
        .phase_jump_enable(phase_jump_enable));

    vsm_src_model src (
        .clk(ref_clk), .pix_cvbs(pix_cvbs), .pix_rgb(pix_rgb), .pix_in_valid(pix_in_valid),
        .pix_in_ready(pix_in_ready), .active_line(active_line),
        .overlay_select_input(overlay_select_input));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] bl(logic [7:0] k, logic [7:0] p, logic [7:0] q);
        logic [16:0] s;
        s = 17'(k) * 17'(p) + 17'(8'hff - k) * 17'(q) + 17'h7f;
        return 8'(s / 17'hff);
    endfunction

    function automatic vsm_pkg::vsm_pix_t mix(logic [2:0] m, logic comp, logic [7:0] k,
                                              vsm_pkg::vsm_pix_t c, vsm_pkg::vsm_pix_t r);
        if (comp) begin
            return {c.y, r.cr, r.cb};
        end
        case (m)
            3'h5: return {bl(k, c.y, r.y), bl(k, c.cr, r.cr), bl(k, c.cb, r.cb)};
            3'h6: return c;
            3'h7: return r;
            default: return {bl(k, r.y, c.y), bl(k, r.cr, c.cr), bl(k, r.cb, c.cb)};
        endcase
    endfunction

    // chroma kept near mid so the overload limiter stays at unity
    function automatic vsm_pkg::vsm_pix_t rpix();
        logic [31:0] x;
        x = xs();
        return {x[23:16], 8'h40 + {1'b0, x[14:8]}, 8'h40 + {1'b0, x[6:0]}};
    endfunction

    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
        @(posedge ref_clk);
        reg_req.wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
        @(posedge ref_clk);
        reg_req.rd <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk($sformatf("reg %h", ad), {16'h0, e}, {16'h0, reg_rdata});
    endtask

    task automatic push_fix(input vsm_pkg::vsm_pix_t c, input vsm_pkg::vsm_pix_t r,
                            input vsm_pkg::vsm_pix_t e);
        bit ok;
        exp_q.push_back(e);
        src.send(c, r, ok);
        if (!ok) begin
            chk("input handshake", 24'h1, 24'h0);
            print_verdict();
        end
    endtask

    task automatic push_send(input logic [2:0] m, input logic comp, input logic [7:0] k);
        vsm_pkg::vsm_pix_t c;
        vsm_pkg::vsm_pix_t r;
        c = rpix();
        r = rpix();
        push_fix(c, r, mix(m, comp, k, c, r));
    endtask

    task automatic wait_empty();
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) begin
            @(posedge ref_clk);
        end
        chk("pixels left", 24'h0, 24'(exp_q.size()));
        if (exp_q.size() != 0) begin
            print_verdict();
        end
    endtask

    // drain side: held, open or stalling at random
    always @(posedge ref_clk) begin
        pix_out_ready <= drain_mode[1] ? 1'(xs()) : drain_mode[0];
    end

    // both lines settle by the falling edge and hold until the next rising edge
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1 && pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
            chk("pixel", exp_q.size() != 0 ? exp_q.pop_front() : ~pix_out, pix_out);
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(8'h04, 8'h01);
        rd(8'h05, 8'h20);
        rd(8'h06, 8'h01);
        chk("entries", 24'h01, {18'h0, std_entry_first, std_entry_second});
        chk("pll", 24'h1, {23'h0, phase_jump_enable});
        wr(8'h04, 8'h3f);
        rd(8'h04, 8'h3f);
        wr(8'h04, 8'h15);
        chk("entries", 24'h15, {18'h0, std_entry_first, std_entry_second});
        rd(8'h07, 8'h00);
        wr(8'h07, 8'h55);
        rd(8'h06, 8'h01);
        wr(8'h05, 8'h01);
        chk("pll", 24'h0, {23'h0, phase_jump_enable});
        wr(8'h05, 8'h00);
        chk("pll", 24'h1, {23'h0, phase_jump_enable});
        $display("test registers done");
        drain_mode <= 2'h2;
        for (int m = 4; m < 8; m++) begin
            for (int k = 0; k < 3; k++) begin
                a = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'(xs());
                wr(8'h05, {3'b000, 3'(m), 2'b00});
                wr(8'h06, a);
                src.set_line(1'b1, k[0]);
                repeat (2) push_send(3'(m), 1'b0, a);
            end
        end
        wr(8'h05, 8'h1a);
        repeat (3) push_send(3'h6, 1'b1, 8'h00);
        $display("test static modes done");
        for (int m = 0; m < 4; m++) begin
            a = m[1] ? 8'(xs()) : {6'h00, 2'(xs())};
            wr(8'h05, {3'b000, 3'(m), 2'b00});
            wr(8'h06, a);
            for (int k = 0; k < 3; k++) begin
                src.set_line(k != 2, k != 1);
                repeat (12) @(posedge ref_clk);
                w = (k != 0) ? 8'h00 : m[1] ? a : 8'hff;
                push_send(3'(m), 1'b0, w);
            end
        end
        wait_empty();
        $display("test soft modes done");
        wr(8'h05, 8'h1c);
        drain_mode <= 2'h0;
        repeat (vsm_pkg::FIFO_DEPTH + 1) push_send(3'h7, 1'b0, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("in_ready full", 24'h0, {23'h0, pix_in_ready});
        drain_mode <= 2'h2;
        wait_empty();
        $display("test buffer done");
        wr(8'h05, 8'h3c);
        src.set_line(1'b1, 1'b0);
        push_fix(24'h101010, 24'h50ff00, 24'h50ff00);
        src.set_line(1'b0, 1'b0);
        src.set_line(1'b1, 1'b0);
        push_fix(24'h101010, 24'h50ff00, 24'h50ef10);
        wr(8'h05, 8'h1c);
        push_fix(24'h101010, 24'h50ff00, 24'h50ff00);
        wait_empty();
        $display("test overload done");
        print_verdict();
    end
endmodule
